// File: tmcfg_top.sv
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tmcfg_defines.svh"

module tmcfg_top
  import tmcfg_pkg::*;
(
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address.
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // AXI4-Lite write data.
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // AXI4-Lite write response.
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address.
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // AXI4-Lite read data.
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Effective mode per channel, toward the timer core.
  output var  logic [19:0] eff_mode,
  output var  logic [4:0]  eff_buf_a,
  output var  logic [4:0]  eff_buf_b,
  output var  logic [4:0]  eff_grc_event_en,
  output var  logic [4:0]  eff_grd_event_en,
  output var  logic [4:0]  eff_legal
);

  tmcfg_reg_t  cfg_q [`TMCFG_NUM_CH];
  tmcfg_eff_t  eff_w [`TMCFG_NUM_CH];

  // Write channel: address and data are latched independently.
  logic        aw_held_q;
  logic        w_held_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  function automatic int addr_to_ch(input logic [11:0] a);
    int c;
    c = -1;
    unique case (a)
      `TMCFG_ADDR_CH0: c = 0;
      `TMCFG_ADDR_CH1: c = 1;
      `TMCFG_ADDR_CH2: c = 2;
      `TMCFG_ADDR_CH3: c = 3;
      `TMCFG_ADDR_CH4: c = 4;
      default:         c = -1;
    endcase
    addr_to_ch = c;
  endfunction

  // Writable bit mask per channel; channels 1 and 2 have no C or D register.
  function automatic logic [7:0] wr_mask(input int ch);
    logic [7:0] m;
    m = 8'h3F;
    if (ch == 1 || ch == 2) begin
      m = 8'h0F;
    end
    wr_mask = m;
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v, input int ch);
    logic [7:0] m;
    m = wr_mask(ch);
    merge = (old_v & ~m) | (new_v & m) | `TMCFG_RSVD_MASK;
  endfunction

  wire         w_aw_in  = s_axi_awvalid && s_axi_awready;
  wire         w_w_in   = s_axi_wvalid && s_axi_wready;
  wire         aw_have  = aw_held_q || w_aw_in;
  wire         w_have   = w_held_q || w_w_in;
  wire [11:0]  wr_addr  = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0]  wr_data  = w_held_q ? w_data_q : s_axi_wdata;
  wire [3:0]   wr_strb  = w_held_q ? w_strb_q : s_axi_wstrb;
  wire         wr_fire  = aw_have && w_have && !bvalid_q;
  wire         wr_hit   = addr_to_ch(wr_addr) >= 0;
  wire [11:0]  rd_addr  = s_axi_araddr;
  wire         rd_fire  = s_axi_arvalid && arready_q;
  wire         rd_stat  = rd_addr == `TMCFG_ADDR_STATUS;
  wire         rd_hit   = (addr_to_ch(rd_addr) >= 0) || rd_stat;

  // Status word packs the legal flag of every channel in bits 4:0.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    for (int i = 0; i < `TMCFG_NUM_CH; i++) begin
      if (addr_to_ch(rd_addr) == i) begin
        rd_word = {24'h00_0000, cfg_q[i]};
      end
    end
    if (rd_stat) begin
      for (int i = 0; i < `TMCFG_NUM_CH; i++) begin
        rd_word[i] = eff_w[i].legal;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end else begin
        if (w_aw_in) begin
          aw_held_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (w_w_in) begin
          w_held_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `TMCFG_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `TMCFG_RESP_OKAY : `TMCFG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Only byte lane 0 carries the register; other lanes are ignored.
  genvar g;
  generate
    for (g = 0; g < `TMCFG_NUM_CH; g++) begin : g_reg
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cfg_q[g] <= `TMCFG_RESET_VAL;
        end else if (wr_fire && wr_strb[0] && addr_to_ch(wr_addr) == g) begin
          cfg_q[g] <= merge(cfg_q[g], wr_data[7:0], g);
        end
      end
      tmcfg_decode #(.CH(g)) tmcfg_decode_i (
        .own_cfg (cfg_q[g]),
        .ch3_cfg (cfg_q[3]),
        .eff     (eff_w[g])
      );
    end
  endgenerate

  // One read at a time: arready drops while the answer is pending.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `TMCFG_RESP_OKAY;
    end else begin
      arready_q <= !rvalid_q && !rd_fire && !arready_q;
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= rd_hit ? `TMCFG_RESP_OKAY : `TMCFG_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  logic        awready_q;
  logic        wready_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end else begin
      awready_q <= !(aw_have && !wr_fire) && !wr_fire && !bvalid_q && !awready_q;
      wready_q  <= !(w_have && !wr_fire) && !wr_fire && !bvalid_q && !wready_q;
    end
  end

  // Outputs registered so the timer core sees glitch-free mode changes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eff_mode         <= 20'h0_0000;
      eff_buf_a        <= 5'h00;
      eff_buf_b        <= 5'h00;
      eff_grc_event_en <= 5'h00;
      eff_grd_event_en <= 5'h00;
      eff_legal        <= 5'h00;
    end else begin
      for (int i = 0; i < `TMCFG_NUM_CH; i++) begin
        eff_mode[i*4 +: 4]  <= eff_w[i].mode;
        eff_buf_a[i]        <= eff_w[i].buf_a;
        eff_buf_b[i]        <= eff_w[i].buf_b;
        eff_grc_event_en[i] <= eff_w[i].grc_event_en;
        eff_grd_event_en[i] <= eff_w[i].grd_event_en;
        eff_legal[i]        <= eff_w[i].legal;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule

`default_nettype wire

// File: tmcfg_defines.svh
`ifndef TMCFG_DEFINES_SVH
`define TMCFG_DEFINES_SVH

// Byte addresses of the five channel mode configuration registers.
`define TMCFG_ADDR_CH0      12'h000
`define TMCFG_ADDR_CH1      12'h004
`define TMCFG_ADDR_CH2      12'h008
`define TMCFG_ADDR_CH3      12'h00C
`define TMCFG_ADDR_CH4      12'h010
// Read-only byte address of the effective (decoded) mode status.
`define TMCFG_ADDR_STATUS   12'h020

`define TMCFG_NUM_CH        5
`define TMCFG_ADDR_W        12

// Field positions inside channel_mode_config.
`define TMCFG_RSVD_HI       7
`define TMCFG_RSVD_LO       6
`define TMCFG_BUF_B_BIT     5
`define TMCFG_BUF_A_BIT     4
`define TMCFG_MD_HI         3
`define TMCFG_MD_LO         0

// Reset value: reserved bits at one, the rest zero.
`define TMCFG_RESET_VAL     8'hC0
`define TMCFG_RSVD_MASK     8'hC0

// AXI responses.
`define TMCFG_RESP_OKAY     2'b00
`define TMCFG_RESP_SLVERR   2'b10

`endif

// File: tmcfg_pkg.sv
package tmcfg_pkg;

  typedef enum logic [3:0] {
    TMCFG_MD_NORMAL   = 4'h0,
    TMCFG_MD_PWM1     = 4'h2,
    TMCFG_MD_PWM2     = 4'h3,
    TMCFG_MD_PHASE1   = 4'h4,
    TMCFG_MD_PHASE2   = 4'h5,
    TMCFG_MD_PHASE3   = 4'h6,
    TMCFG_MD_PHASE4   = 4'h7,
    TMCFG_MD_RSYNC    = 4'h8,
    TMCFG_MD_CPWM_PK  = 4'hD,
    TMCFG_MD_CPWM_VL  = 4'hE,
    TMCFG_MD_CPWM_PV  = 4'hF
  } tmcfg_mode_t;

  typedef struct packed {
    logic [1:0] reserved;
    logic       buffer_pair_b_enable;
    logic       buffer_pair_a_enable;
    logic [3:0] mode_select_field;
  } tmcfg_reg_t;

  // One channel's decoded, effective configuration.
  typedef struct packed {
    logic        legal;
    logic        buf_b;
    logic        buf_a;
    logic        grd_event_en;
    logic        grc_event_en;
    logic [3:0]  mode;
  } tmcfg_eff_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } tmcfg_wreq_t;

endpackage

// File: tmcfg_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "tmcfg_defines.svh"

// Decodes one channel's stored configuration into its effective mode.
module tmcfg_decode
  import tmcfg_pkg::*;
#(
  parameter int CH = 0
) (
  // Stored register of this channel and of channel 3.
  input  wire tmcfg_reg_t own_cfg,
  input  wire tmcfg_reg_t ch3_cfg,
  // Effective result.
  output var  tmcfg_eff_t eff
);

  function automatic logic is_combined(input logic [3:0] md);
    is_combined = (md == TMCFG_MD_RSYNC) || (md[3:2] == 2'b11 && md[1:0] != 2'b00);
  endfunction

  function automatic logic md_legal(input logic [3:0] md, input int ch);
    logic ok;
    ok = 1'b0;
    unique case (md)
      TMCFG_MD_NORMAL, TMCFG_MD_PWM1: ok = 1'b1;
      TMCFG_MD_PWM2:                  ok = (ch < 3);
      TMCFG_MD_PHASE1, TMCFG_MD_PHASE2,
      TMCFG_MD_PHASE3, TMCFG_MD_PHASE4: ok = (ch == 1) || (ch == 2);
      TMCFG_MD_RSYNC, TMCFG_MD_CPWM_PK,
      TMCFG_MD_CPWM_VL, TMCFG_MD_CPWM_PV: ok = (ch == 3);
      default:                        ok = 1'b0;
    endcase
    md_legal = ok;
  endfunction

  wire        follow_ch3 = (CH == 4) && is_combined(ch3_cfg.mode_select_field);
  wire tmcfg_reg_t src = follow_ch3 ? ch3_cfg : own_cfg;
  wire [3:0]  md    = src.mode_select_field;
  wire        buf_b = src.buffer_pair_b_enable;
  wire        buf_a = src.buffer_pair_a_enable;

  assign eff.mode         = md;
  assign eff.buf_b        = buf_b;
  assign eff.buf_a        = buf_a;
  assign eff.grd_event_en = (CH != 1) && (CH != 2) && !buf_b;
  assign eff.grc_event_en = (CH != 1) && (CH != 2) && !buf_a;
  assign eff.legal        = follow_ch3 ? 1'b1 : md_legal(md, CH);

endmodule

`default_nettype wire

// File: tmcfg_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module tmcfg_top_asserts (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Effective configuration.
  input wire logic [19:0] eff_mode,
  input wire logic [4:0]  eff_buf_a,
  input wire logic [4:0]  eff_buf_b,
  input wire logic [4:0]  eff_grc_event_en,
  input wire logic [4:0]  eff_grd_event_en,
  input wire logic [4:0]  eff_legal
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // The decoded outputs sit at zero until the first edge after reset, so the
  // pairing checks wait until they have settled.
  logic [1:0] up_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (s_wr_taken |=> s_axi_bvalid) else $error("write answer late");
  AST_RD_ANSWER: assert property (s_rd_taken |=> s_axi_rvalid) else $error("read answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
  AST_CH12_BUF: assert property ({eff_buf_a[2:1], eff_buf_b[2:1]} == 4'h0 &&
    {eff_grc_event_en[2:1], eff_grd_event_en[2:1]} == 4'h0) else $error("channel 1 or 2 buffered");
  AST_GRC_OFF: assert property (up_q == 2'h3 |->
    {eff_grc_event_en[4:3], eff_grc_event_en[0]} == ~{eff_buf_a[4:3], eff_buf_a[0]})
    else $error("register C event wrong");
  AST_GRD_OFF: assert property (up_q == 2'h3 |->
    {eff_grd_event_en[4:3], eff_grd_event_en[0]} == ~{eff_buf_b[4:3], eff_buf_b[0]})
    else $error("register D event wrong");
  AST_CH4_FOLLOW: assert property (eff_mode[15:12] inside {4'h8, 4'hD, 4'hE, 4'hF} |->
    eff_mode[19:16] == eff_mode[15:12] && eff_buf_a[4] == eff_buf_a[3] && eff_buf_b[4] == eff_buf_b[3])
    else $error("channel 4 not following");
  AST_CH4_LEGAL: assert property (eff_mode[15:12] inside {4'h8, 4'hD, 4'hE, 4'hF} |->
    eff_legal[4:3] == 2'b11) else $error("combined mode flagged illegal");
endmodule
`default_nettype wire

// File: test_tmcfg_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module test_tmcfg_top;
  import tmcfg_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [19:0] eff_mode;
  logic [4:0]  eff_buf_a, eff_buf_b, eff_grc_event_en, eff_grd_event_en, eff_legal;
  logic [7:0]  cfg [5] = '{default: 8'hC0};
  logic [7:0]  tbl [20] = '{8'h00, 8'h02, 8'h03, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h22, 8'h24,
                            8'h30, 8'h32, 8'h38, 8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h42, 8'h30};
  logic [33:0] rq [$], e;
  logic [1:0]  bq [$], bx;
  logic [31:0] lfsr = 32'h0000_c252;
  int          mismatches = 0, total_checks = 0;
  tmcfg_top tmcfg_top_i (.*);
  always #2.5 aclk = ~aclk;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic results;
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      bx = bq.pop_front();
      `CHK(s_axi_bresp, bx)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      `CHK(s_axi_rresp, e[33:32])
      if (e[33:32] == 2'b00) `CHK(s_axi_rdata, e[31:0])
    end
  end
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] r);
    int n;
    @(posedge aclk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {lfsr[31:8], d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 99);
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid) begin mismatches++; results(); end
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] x);
    int n;
    @(posedge aclk);
    rq.push_back(x);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 99);
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid) begin mismatches++; results(); end
  endtask
  // Whether a mode code is one that the given channel is permitted to run.
  function automatic logic ok_code(input logic [3:0] m, input int ch);
    if (m == 4'h0 || m == 4'h2) return 1'b1;
    if (m == 4'h3) return (ch < 3);
    if (m[3:2] == 2'b01) return (ch == 1 || ch == 2);
    if (m inside {4'h8, 4'hD, 4'hE, 4'hF}) return (ch == 3);
    return 1'b0;
  endfunction
  // Channel 4 takes channel 3's mode and buffer bits while channel 3 runs a combined mode.
  task automatic chk_eff;
    logic [7:0] c;
    logic       f;
    logic [4:0] lg;
    repeat (2) @(posedge aclk);
    #1;
    for (int i = 0; i < 5; i++) begin
      f = (i == 4) && (cfg[3][3:0] inside {4'h8, 4'hD, 4'hE, 4'hF});
      c = f ? cfg[3] : cfg[i];
      lg[i] = f || ok_code(c[3:0], i);
      `CHK(eff_mode[4*i +: 4], c[3:0])
      `CHK({eff_buf_b[i], eff_buf_a[i]}, c[5:4])
      `CHK({eff_grd_event_en[i], eff_grc_event_en[i]}, (i == 1 || i == 2) ? 2'b00 : ~c[5:4])
      `CHK(eff_legal[i], lg[i])
    end
    rd(12'h020, {29'h0000_0000, lg});
  endtask
  task automatic setc(input logic [7:0] t, input logic [1:0] b);
    int ch;
    ch = int'(t[7:4]);
    wr(12'(4 * ch), {2'b11, b, t[3:0]}, 4'h1, 2'b00);
    cfg[ch] = {2'b11, (ch == 1 || ch == 2) ? 2'b00 : b, t[3:0]};
    chk_eff();
    rd(12'(4 * ch), {26'h000_0000, cfg[ch]});
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(12'(4 * i), 34'h0_0000_00C0);
    foreach (tbl[k]) setc(tbl[k], 2'(k));
    wr(12'h020, 8'hFF, 4'h1, 2'b10);
    wr(12'h030, 8'hFF, 4'h1, 2'b10);
    rd(12'h030, 34'h2_0000_0000);
    wr(12'h000, 8'hF5, 4'h0, 2'b00);
    rd(12'h000, {26'h000_0000, cfg[0]});
    for (int k = 0; k < 40; k++) begin
      lfsr = nxt(lfsr);
      setc(tbl[lfsr[15:8] % 20], lfsr[1:0]);
    end
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    cfg = '{default: 8'hC0};
    for (int i = 0; i < 5; i++) rd(12'(4 * i), 34'h0_0000_00C0);
    chk_eff();
    results();
  end
endmodule
bind tmcfg_top tmcfg_top_asserts tmcfg_top_asserts_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .eff_mode, .eff_buf_a, .eff_buf_b, .eff_grc_event_en, .eff_grd_event_en, .eff_legal);
`default_nettype wire
